/* hdl/fbsup_regs.svh */
// Constants for the fieldbus option fault supervisor.
// Assumes inclusion by the package and by the supervisor module only.
`ifndef FBSUP_REGS_SVH
`define FBSUP_REGS_SVH
// Fieldbus state encodings (low to high)
`define FBSUP_ST_INIT 4'h1
`define FBSUP_ST_PREOP 4'h2
`define FBSUP_ST_SAFEOP 4'h4
`define FBSUP_ST_OP 4'h8
// Drive fault codes, 16-bit numeric form of the displayed codes
`define FBSUP_F_NONE 16'h0000
`define FBSUP_F_A01 16'ha001
`define FBSUP_F_A03 16'ha003
`define FBSUP_F_A04 16'ha004
`define FBSUP_F_A30 16'ha030
`define FBSUP_F_A43 16'ha043
`define FBSUP_F_B00 16'hb000
`define FBSUP_F_B02 16'hb002
`define FBSUP_F_C00 16'hc000
`define FBSUP_F_C02 16'hc002
`define FBSUP_F_X30 16'hf030
`define FBSUP_F_X32 16'hf032
// Card type zero means slot empty
`define FBSUP_CARD_NONE 8'h00
`endif

/* hdl/fbsup_pkg.sv */
// Types for the fieldbus option fault supervisor.
// Assumes fbsup_regs.svh is reachable on the include path.
`include "fbsup_regs.svh"
package fbsup_pkg;
  // Fieldbus state machine of the option board
  typedef enum logic [3:0] {
    FBSUP_INIT = 4'h1,
    FBSUP_PREOP = 4'h2,
    FBSUP_SAFEOP = 4'h4,
    FBSUP_OP = 4'h8
  } fbsup_bus_e;
  // Whole state of the supervisor
  typedef struct packed {
    fbsup_bus_e busState;
    logic busError;
    logic driveFault;
    logic [15:0] faultCode;
    logic outSyncEnable;
    logic [7:0] cardAPrev;
    logic cardAValid;
  } fbsup_state_s;
endpackage : fbsup_pkg

/* hdl/fbsup_supervisor.sv */
// Fault supervision for a fieldbus option card on a motor drive: bus state,
// bus error raise/clear, drive fault codes and fault latching.
// Assumes all inputs are synchronous to mclk; the master and drive processor
// deliver one-cycle event pulses.
`timescale 1ns/1ns
`include "fbsup_regs.svh"

module fbsup_supervisor #(
  parameter int CARD_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Fieldbus master side
  input wire logic stateReqValid,
  input wire logic [3:0] stateReq,
  input wire logic watchdogEnable,
  input wire logic watchdogExpired,
  // Drive side
  input wire logic driveOpEnabled,
  input wire logic driveRunning,
  input wire logic linkSumCheckErr,
  input wire logic optionIdentityCheckErr,
  input wire logic faultReset,
  // Option slot reports
  input wire logic [CARD_W-1:0] cardA,
  input wire logic [CARD_W-1:0] cardB,
  input wire logic [CARD_W-1:0] cardC,
  input wire logic cardBPermitted,
  input wire logic cardCCompatible,
  input wire logic cardCIsComm,
  input wire logic cardAIsComm,
  input wire logic cardAFault,
  input wire logic cardAFaultSel,
  input wire logic [3:0] cardACommCode,
  // Status outputs
  output logic [3:0] busState,
  output logic busError,
  output logic driveFault,
  output logic [15:0] faultCode,
  output logic outSyncEnable
);

  fbsup_pkg::fbsup_state_s state_reg;
  fbsup_pkg::fbsup_state_s state_next;
  logic [3:0] reqState;
  logic fallFromOp;
  logic rising;
  logic dupA;
  logic dupB;
  logic [15:0] newCode;

  // Transition decode of the master's state request
  always_comb begin
    reqState = stateReq;
    fallFromOp = stateReqValid && state_reg.busState == fbsup_pkg::FBSUP_OP &&
                 (reqState == `FBSUP_ST_SAFEOP || reqState == `FBSUP_ST_PREOP);
    rising = stateReqValid && reqState > state_reg.busState;
    // Empty slots never count as duplicates
    dupA = cardA != `FBSUP_CARD_NONE && (cardA == cardB || cardA == cardC);
    dupB = cardB != `FBSUP_CARD_NONE && cardB == cardC;
  end

  // Fault priority: link errors first, then slot faults; one code held at a time
  always_comb begin
    newCode = `FBSUP_F_NONE;
    if (linkSumCheckErr) begin
      newCode = `FBSUP_F_X32;
    end else if (optionIdentityCheckErr) begin
      newCode = `FBSUP_F_X30;
    end else if (state_reg.cardAValid && driveRunning && cardA != state_reg.cardAPrev) begin
      newCode = `FBSUP_F_A01;
    end else if (cardAFault && cardAIsComm) begin
      newCode = `FBSUP_F_A30 + {12'h000, cardACommCode} > `FBSUP_F_A43 ?
                `FBSUP_F_A43 : `FBSUP_F_A30 + {12'h000, cardACommCode};
    end else if (cardAFault) begin
      newCode = cardAFaultSel ? `FBSUP_F_A04 : `FBSUP_F_A03;
    end else if (cardB != `FBSUP_CARD_NONE && !cardBPermitted) begin
      newCode = `FBSUP_F_B00;
    end else if (cardC != `FBSUP_CARD_NONE && (!cardCCompatible || cardCIsComm)) begin
      newCode = `FBSUP_F_C00;
    end else if (dupA || dupB) begin
      newCode = dupB ? `FBSUP_F_C02 : `FBSUP_F_B02;
    end
  end

  // Next-state logic for the whole supervisor
  always_comb begin
    state_next = state_reg;
    state_next.cardAPrev = cardA;
    state_next.cardAValid = 1'b1;
    if (stateReqValid) begin
      state_next.busState = fbsup_pkg::fbsup_bus_e'(reqState);
    end
    if (rising) begin
      state_next.busError = 1'b0;
      state_next.outSyncEnable = 1'b1;
    end
    if (fallFromOp && driveOpEnabled) begin
      state_next.busError = 1'b1;
    end
    if (watchdogEnable && watchdogExpired && state_reg.busState == fbsup_pkg::FBSUP_OP) begin
      state_next.busState = fbsup_pkg::FBSUP_SAFEOP;
      state_next.busError = 1'b1;
    end
    if (linkSumCheckErr || optionIdentityCheckErr) begin
      state_next.outSyncEnable = 1'b0;
      if (state_reg.busState == fbsup_pkg::FBSUP_OP) begin
        state_next.busState = fbsup_pkg::FBSUP_SAFEOP;
      end
    end
    // latch until reset; a new fault beats a reset in the same cycle
    if (faultReset) begin
      state_next.driveFault = 1'b0;
      state_next.faultCode = `FBSUP_F_NONE;
    end
    if (newCode != `FBSUP_F_NONE) begin
      state_next.driveFault = 1'b1;
      // First code is kept; a reset in the same cycle lets the new code in, else flag and code disagree
      if (!state_reg.driveFault || faultReset) begin
        state_next.faultCode = newCode;
      end
    end
  end

  // State register; invalid requests only arrive from a faulty master
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg.busState <= fbsup_pkg::FBSUP_INIT;
      state_reg.busError <= 1'b0;
      state_reg.driveFault <= 1'b0;
      state_reg.faultCode <= `FBSUP_F_NONE;
      state_reg.outSyncEnable <= 1'b1;
      state_reg.cardAPrev <= `FBSUP_CARD_NONE;
      state_reg.cardAValid <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign busState = state_reg.busState;
  assign busError = state_reg.busError;
  assign driveFault = state_reg.driveFault;
  assign faultCode = state_reg.faultCode;
  assign outSyncEnable = state_reg.outSyncEnable;

  AST_FALL_RAISES: assert property (@(posedge mclk) disable iff (sys_rst)
    fallFromOp && driveOpEnabled |=> busError)
    else $error("bus error not raised on OP fall");
  AST_RISE_CLEARS: assert property (@(posedge mclk) disable iff (sys_rst)
    rising && !watchdogExpired |=> !busError)
    else $error("bus error not cleared on rise");
  AST_WD_SAFEOP: assert property (@(posedge mclk) disable iff (sys_rst)
    watchdogEnable && watchdogExpired && busState == `FBSUP_ST_OP |=>
    busError && busState == `FBSUP_ST_SAFEOP)
    else $error("watchdog did not drop to SAFEOP");
  AST_SUMCHK_CODE: assert property (@(posedge mclk) disable iff (sys_rst)
    linkSumCheckErr && !driveFault |=> faultCode == `FBSUP_F_X32)
    else $error("sum-check fault code wrong");
  AST_SYNC_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
    (linkSumCheckErr || optionIdentityCheckErr) |=> !outSyncEnable)
    else $error("output sync not disabled");
  AST_SWAP_CODE: assert property (@(posedge mclk) disable iff (sys_rst)
    !driveFault && !linkSumCheckErr && !optionIdentityCheckErr && driveRunning &&
    state_reg.cardAValid && $changed(cardA) |=> faultCode == `FBSUP_F_A01)
    else $error("card swap fault missing");
  AST_TERT_CODE: assert property (@(posedge mclk) disable iff (sys_rst)
    cardC != `FBSUP_CARD_NONE && (!cardCCompatible || cardCIsComm) |=> driveFault)
    else $error("tertiary fault missing");
  AST_FAULT_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    driveFault && !faultReset |=> driveFault)
    else $error("fault dropped without reset");
  AST_RESET_SET_WINS: assert property (@(posedge mclk) disable iff (sys_rst)
    faultReset && optionIdentityCheckErr && !linkSumCheckErr |=> driveFault && faultCode == `FBSUP_F_X30)
    else $error("fault lost to a same-cycle reset");

  // Fault latch checks: a slot A fault, a barred slot B card or a B/C duplicate must leave the drive faulted
  // option fault check
  AST_SLOTA_FAULT: assert property (@(posedge mclk) disable iff (sys_rst)
    cardAFault |=> driveFault)
    else $error("primary slot fault not latched");
  AST_SEC_FAULT: assert property (@(posedge mclk) disable iff (sys_rst)
    cardB != `FBSUP_CARD_NONE && !cardBPermitted |=> driveFault)
    else $error("secondary slot fault not latched");
  AST_DUP_FAULT: assert property (@(posedge mclk) disable iff (sys_rst)
    cardB != `FBSUP_CARD_NONE && cardB == cardC |=> driveFault)
    else $error("duplicate card fault not latched");

endmodule : fbsup_supervisor

/* testbench/fbsup_master_model.sv */
// Behavioural fieldbus master that issues state requests.
// Assumes callers enter just after a rising edge of mclk.
`timescale 1ns/1ns
module fbsup_master_model (
  // Clock
  input wire logic mclk,
  // State request
  output logic stateReqValid,
  output logic [3:0] stateReq
);
  // Idle values at time zero
  initial begin
    stateReqValid = 1'b0;
    stateReq = 4'h0;
  end
  // One-cycle request, then one idle edge so back-to-back calls never re-raise valid in the same step
  // Idle field shows the inverse so a stale copy never looks valid
  task request(input logic [3:0] st);
    stateReqValid = 1'b1;
    stateReq = st;
    @(posedge mclk);
    #5;
    stateReqValid = 1'b0;
    stateReq = ~st;
    @(posedge mclk);
    #5;
  endtask
endmodule // fbsup_master_model

/* testbench/tb_top.sv */
// Self-checking bench for the fault supervisor, random and corner cases.
// Assumes the master model makes state requests; all other inputs are driven here.
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic watchdogEnable = 1'b1, watchdogExpired = 1'b0, driveOpEnabled = 1'b0, driveRunning;
  logic linkSumCheckErr = 1'b0, optionIdentityCheckErr = 1'b0, faultReset = 1'b0;
  logic [7:0] cardA, cardB, cardC, rnd;
  logic cardBPermitted, cardCCompatible, cardCIsComm, cardAIsComm, cardAFault, cardAFaultSel;
  logic [3:0] cardACommCode, stateReq, busState;
  logic stateReqValid, busError, driveFault, outSyncEnable;
  logic [15:0] faultCode;
  int bad_count = 0, check_count = 0, seed = 32'h4208, k;
  logic [3:0] seqSt [5] = '{4'h8, 4'h4, 4'h8, 4'h2, 4'h4};
  logic seqErr [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  fbsup_supervisor dut (.mclk, .sys_rst, .stateReqValid, .stateReq, .watchdogEnable, .watchdogExpired,
    .driveOpEnabled, .driveRunning, .linkSumCheckErr, .optionIdentityCheckErr, .faultReset, .cardA, .cardB,
    .cardC, .cardBPermitted, .cardCCompatible, .cardCIsComm, .cardAIsComm, .cardAFault, .cardAFaultSel,
    .cardACommCode, .busState, .busError, .driveFault, .faultCode, .outSyncEnable);
  fbsup_master_model master (.mclk, .stateReqValid, .stateReq);
  // Clock, 50 ns period
  initial begin
    forever #25 mclk = ~mclk;
  end
  // Inputs move 5 ns after the edge so sampling never races
  task step(int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask
  task chk(string n, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Benign slot setup: distinct cards, all allowed
  task dflt();
    {cardA, cardB, cardC} = 24'h010203;
    {cardBPermitted, cardCCompatible, cardCIsComm, cardAIsComm, cardAFault, cardAFaultSel, driveRunning} = 7'h60;
  endtask
  // Cause removed first: a fault in the reset cycle would win
  task clearF();
    dflt();
    faultReset = 1'b1;
    step(1);
    faultReset = 1'b0;
    chk("faultClr", 16'h0, faultCode);
    chk("faultFlagClr", 16'h0, 16'(driveFault));
  endtask
  function logic [15:0] expCode(int i);
    case (i)
      0: return 16'ha001;
      1: return 16'ha003;
      2: return 16'ha004;
      3: return 16'ha030 + 16'(cardACommCode);
      4: return 16'hb000;
      5, 6: return 16'hc000;
      default: return (cardB == cardC) ? 16'hc002 : 16'hb002;
    endcase
  endfunction
  task finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard, far beyond the roughly 70 cycles used
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  initial begin
    dflt();
    cardACommCode = 4'h0;
    step(3);
    chk("reset", 16'h0009, {9'h0, busState, busError, driveFault, outSyncEnable});
    sys_rst = 1'b0;
    step(1);
    driveOpEnabled = 1'b1;
    for (k = 0; k < 5; k++) begin
      master.request(seqSt[k]);
      chk("state", 16'(seqSt[k]), 16'(busState));
      chk("busErr", 16'(seqErr[k]), 16'(busError));
    end
    driveOpEnabled = 1'b0;
    master.request(4'h8);
    master.request(4'h2);
    chk("busErrIdle", 16'h0, 16'(busError));
    master.request(4'h8);
    driveOpEnabled = 1'b1;
    $display("test states done");
    for (k = 0; k < 2; k++) begin
      watchdogEnable = k[0];
      watchdogExpired = 1'b1;
      step(1);
      watchdogExpired = 1'b0;
      chk("wdState", k ? 16'h4 : 16'h8, 16'(busState));
      chk("wdErr", 16'(k), 16'(busError));
    end
    $display("test watchdog done");
    for (k = 0; k < 2; k++) begin
      master.request(4'h8);
      chk("syncBack", 16'h1, 16'(outSyncEnable));
      {linkSumCheckErr, optionIdentityCheckErr} = k ? 2'b01 : 2'b10;
      step(1);
      {linkSumCheckErr, optionIdentityCheckErr} = 2'b01 - 2'(k);
      step(1);
      {linkSumCheckErr, optionIdentityCheckErr} = 2'b00;
      chk("linkCode", k ? 16'hf030 : 16'hf032, faultCode);
      chk("linkState", 16'h0042, {8'h0, busState, 2'b0, driveFault, outSyncEnable});
      clearF();
    end
    // Corner: a fault arriving with the reset is kept, with its own code
    linkSumCheckErr = 1'b1;
    step(1);
    {faultReset, linkSumCheckErr, optionIdentityCheckErr} = 3'b101;
    step(1);
    {faultReset, optionIdentityCheckErr} = 2'b00;
    chk("resetRace", 16'hf030, faultCode);
    clearF();
    $display("test link done");
    for (k = 0; k < 9; k++) begin
      rnd = 8'h40 | 8'($random(seed));
      cardACommCode = 4'($random(seed));
      case (k)
        0: {driveRunning, cardA} = {1'b1, rnd};
        1: cardAFault = 1'b1;
        2: {cardAFault, cardAFaultSel} = 2'b11;
        3: {cardAFault, cardAIsComm} = 2'b11;
        4: cardBPermitted = 1'b0;
        5: cardCCompatible = 1'b0;
        6: cardCIsComm = 1'b1;
        7: {cardA, cardB} = {rnd, rnd};
        default: {cardB, cardC} = {rnd, rnd};
      endcase
      step(1);
      chk("slotCode", expCode(k), faultCode);
      step(2);
      chk("slotHeld", {15'h0, 1'b1}, 16'(driveFault));
      clearF();
    end
    $display("test slots done");
    finish_test();
  end
endmodule // tb_top
